/* ptm_pkg.sv */
// Package for the prescaled timer with capture and match: offsets, fields, types
`default_nettype none
package ptm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PLIM = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PCNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MCTL = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MATCH0 = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CCTL = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_CAP0 = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_EXTM = 8'h3c;
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h70;
  localparam logic [ADDR_W-1:0] OFF_IMASK = 8'h74;
  // Control bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_RST = 1;
  // Mode register: bits 1:0 count source, bits 3:2 capture input used as clock
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_RISE = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;
  // Match control: three bits per channel
  localparam int MC_INT = 0;
  localparam int MC_RST = 1;
  localparam int MC_STOP = 2;
  // Capture control: three bits per channel
  localparam int CC_RISE = 0;
  localparam int CC_FALL = 1;
  localparam int CC_INT = 2;
  // External match control: bits 3:0 pin state, actions at 4+2n
  localparam int EM_ACT_POS = 4;
  localparam logic [1:0] EM_NONE = 2'h0;
  localparam logic [1:0] EM_LOW = 2'h1;
  localparam logic [1:0] EM_HIGH = 2'h2;
  localparam logic [1:0] EM_TOGGLE = 2'h3;
  localparam int FLAG_CAP_POS = 4;
  localparam logic [DATA_W-1:0] RESET_VAL = 32'h0000_0000;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ptm_req_t;
endpackage : ptm_pkg
`default_nettype wire

/* ptm_regs.sv */
// Small register memory holding match and capture words, registered read
`default_nettype none
module ptm_regs #(
  parameter int N = 8,
  parameter int AW = 3
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [N-1:0] we,
  input wire logic [N*32-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [31:0] rdata,
  output logic [N*32-1:0] all
);
  logic [31:0] mem_q [N];
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_w
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          mem_q[g] <= ptm_pkg::RESET_VAL;
        end else if (we[g]) begin
          mem_q[g] <= wdata[g*32 +: 32];
        end
      end
      assign all[g*32 +: 32] = mem_q[g];
    end
  endgenerate
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= ptm_pkg::RESET_VAL;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule : ptm_regs
`default_nettype wire

/* ptm_timer.sv */
// Prescaled 32-bit timer with four match channels and up to four capture channels
// Function
// - 32-bit count stepped through 32-bit prescaler
// - Count clock cycles or external clock
// - Counter mode clocks from chosen capture input
// - Capture inputs snapshot count on edges
// - Capture may raise interrupt per channel
// - Four match compares, continuous with interrupt
// - Stop-on-match halts timer, optional interrupt
// - Reset-on-match clears count, optional interrupt
// - Match drives output low, high, toggle, none
// - External match control holds per-channel actions
// - One match output fans out to pins
// - Pinless match channels keep internal behaviour
// - Instance pin counts set by parameters
// - Six instances, each at its base
// - Count steps every limit-plus-one cycles
// - Eight flags, cleared by writing ones
// - Control register enables or resets counters
// - Stop halts count and prescaler both
`default_nettype none
module ptm_timer #(
  parameter int NCAP = 4,
  parameter int NMAT = 4,
  parameter int NPIN = 1,
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic [3:0] capture_input,
  output logic [3:0] match_output,
  output logic [NPIN*4-1:0] match_pins,
  output logic irq
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } ptm_state_t;

  ptm_pkg::ptm_req_t req;
  logic sel;
  logic [7:0] off;
  logic wr;
  logic rd;
  assign req.addr = bus_addr[7:0];
  assign req.wdata = bus_wdata;
  assign req.wr = bus_wr;
  assign req.rd = bus_rd;
  // Instance decode: upper address bits must equal this instance's base
  assign sel = (bus_addr[31:8] == BASE_ADDR[31:8]);
  assign off = req.addr;
  assign wr = req.wr && sel;
  assign rd = req.rd && sel;

  logic [1:0] timer_control_q;
  logic [31:0] timer_count_q;
  logic [31:0] prescale_limit_q;
  logic [31:0] prescale_counter_q;
  logic [11:0] mctl_q;
  logic [11:0] cctl_q;
  logic [11:0] external_match_control_q;
  logic [3:0] mode_q;
  logic [7:0] interrupt_flags_q;
  logic [7:0] imask_q;
  logic [3:0] cap_d1_q;
  logic [3:0] cap_d2_q;
  ptm_state_t state_q;
  logic [31:0] rd_reg_q;
  logic use_mem_q;

  logic [3:0] cap_live;
  assign cap_live = capture_input & 4'((1 << NCAP) - 1);

  // Input history for edge detection; inputs are synchronous
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cap_d1_q <= 4'h0;
      cap_d2_q <= 4'h0;
    end else begin
      cap_d1_q <= cap_live;
      cap_d2_q <= cap_d1_q;
    end
  end
  logic [3:0] rise;
  logic [3:0] fall;
  assign rise = cap_d1_q & ~cap_d2_q;
  assign fall = ~cap_d1_q & cap_d2_q;

  // Count tick source
  logic ext_edge;
  logic [1:0] csel;
  assign csel = mode_q[3:2];
  always_comb begin
    case (mode_q[1:0])
      ptm_pkg::MODE_RISE: ext_edge = rise[csel];
      ptm_pkg::MODE_FALL: ext_edge = fall[csel];
      ptm_pkg::MODE_BOTH: ext_edge = rise[csel] | fall[csel];
      default: ext_edge = 1'b1;
    endcase
  end

  logic running;
  logic count_step;
  logic pre_wrap;
  logic [31:0] mv [4];
  logic [3:0] hit;
  logic [3:0] eq;
  logic [3:0] eq_q;
  logic match_rst;
  logic match_stop;
  // The enable gates counting at once; a stop holds the count in its own cycle and clears the enable at that edge
  assign running = (state_q == ST_RUN) && timer_control_q[ptm_pkg::CTRL_EN];
  assign pre_wrap = (prescale_counter_q == prescale_limit_q);
  // Timer mode ticks every clock, counter mode ticks on selected edge
  assign count_step = running && ext_edge && pre_wrap;

  genvar m;
  generate
    for (m = 0; m < 4; m++) begin : g_match
      // Match holds regardless of pin presence
      assign eq[m] = running && (timer_count_q == mv[m]);
      // One event per arrival at the value, so a held count does not act again
      assign hit[m] = eq[m] && !eq_q[m];
    end
  endgenerate
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      eq_q <= 4'h0;
    end else begin
      eq_q <= eq;
    end
  end
  always_comb begin
    match_rst = 1'b0;
    match_stop = 1'b0;
    for (int i = 0; i < 4; i++) begin
      // Reset lands at the step that ends the match period
      match_rst = match_rst | (eq[i] & mctl_q[i*3+ptm_pkg::MC_RST]);
      match_stop = match_stop | (hit[i] & mctl_q[i*3+ptm_pkg::MC_STOP]);
    end
  end

  // Run state follows the enable and reset bits and stop events
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (timer_control_q[ptm_pkg::CTRL_EN]) state_q <= ST_RUN;
        ST_RUN: begin
          if (timer_control_q[ptm_pkg::CTRL_RST]) begin
            state_q <= ST_HOLD;
          end else if (!timer_control_q[ptm_pkg::CTRL_EN]) begin
            state_q <= ST_IDLE;
          end
        end
        ST_HOLD: if (!timer_control_q[ptm_pkg::CTRL_RST]) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Control register; a stop event clears the enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_control_q <= 2'h0;
    end else if (wr && off == ptm_pkg::OFF_CTRL) begin
      timer_control_q <= bus_wdata[1:0];
    end else if (match_stop) begin
      timer_control_q[ptm_pkg::CTRL_EN] <= 1'b0;
    end
  end

  // Prescaler
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prescale_counter_q <= ptm_pkg::RESET_VAL;
    end else if (timer_control_q[ptm_pkg::CTRL_RST]) begin
      prescale_counter_q <= ptm_pkg::RESET_VAL;
    end else if (wr && off == ptm_pkg::OFF_PCNT) begin
      prescale_counter_q <= bus_wdata;
    end else if (match_stop) begin
      prescale_counter_q <= prescale_counter_q;
    end else if (running && ext_edge) begin
      prescale_counter_q <= pre_wrap ? ptm_pkg::RESET_VAL : prescale_counter_q + 32'h1;
    end
  end

  // Timer count
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_count_q <= ptm_pkg::RESET_VAL;
    end else if (timer_control_q[ptm_pkg::CTRL_RST]) begin
      timer_count_q <= ptm_pkg::RESET_VAL;
    end else if (wr && off == ptm_pkg::OFF_COUNT) begin
      timer_count_q <= bus_wdata;
    end else if (match_stop) begin
      timer_count_q <= timer_count_q;
    end else if (match_rst && count_step) begin
      timer_count_q <= ptm_pkg::RESET_VAL;
    end else if (count_step) begin
      timer_count_q <= timer_count_q + 32'h1;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prescale_limit_q <= ptm_pkg::RESET_VAL;
      mctl_q <= 12'h0;
      cctl_q <= 12'h0;
      mode_q <= 4'h0;
      imask_q <= 8'hff;
    end else if (wr) begin
      case (off)
        ptm_pkg::OFF_PLIM: prescale_limit_q <= bus_wdata;
        ptm_pkg::OFF_MCTL: mctl_q <= bus_wdata[11:0];
        ptm_pkg::OFF_CCTL: cctl_q <= bus_wdata[11:0];
        ptm_pkg::OFF_MODE: mode_q <= bus_wdata[3:0];
        ptm_pkg::OFF_IMASK: imask_q <= bus_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Match and capture words in the register memory
  logic [7:0] mem_we;
  logic [255:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic [255:0] mem_all;
  logic [3:0] cap_ev;
  logic [2:0] mem_raddr;
  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_cap
      assign cap_ev[c] = (rise[c] & cctl_q[c*3+ptm_pkg::CC_RISE])
                       | (fall[c] & cctl_q[c*3+ptm_pkg::CC_FALL]);
      assign mem_we[c] = wr && (off == ptm_pkg::OFF_MATCH0 + 8'(c*4));
      assign mem_wdata[c*32 +: 32] = bus_wdata;
      assign mem_we[4+c] = cap_ev[c];
      assign mem_wdata[(4+c)*32 +: 32] = timer_count_q;
      assign mv[c] = mem_all[c*32 +: 32];
    end
  endgenerate
  assign mem_raddr = (off >= ptm_pkg::OFF_CAP0) ? 3'(4 + ((off - ptm_pkg::OFF_CAP0) >> 2))
                                                : 3'((off - ptm_pkg::OFF_MATCH0) >> 2);

  ptm_regs #(.N(8), .AW(3)) u_regs (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .we(mem_we),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata),
    .all(mem_all)
  );

  // Interrupt flags: events set, write of ones or a read clears; set wins
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      flag_set[i] = hit[i] & mctl_q[i*3+ptm_pkg::MC_INT];
      flag_set[ptm_pkg::FLAG_CAP_POS+i] = cap_ev[i] & cctl_q[i*3+ptm_pkg::CC_INT];
    end
    flag_clr = 8'h0;
    if (wr && off == ptm_pkg::OFF_FLAGS) flag_clr = bus_wdata[7:0];
    if (rd && off == ptm_pkg::OFF_FLAGS) flag_clr = 8'hff;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_flags_q <= 8'h0;
    end else begin
      interrupt_flags_q <= (interrupt_flags_q & ~flag_clr) | flag_set;
    end
  end
  assign irq = |(interrupt_flags_q & imask_q);

  // External match outputs
  logic [3:0] emr_next;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      emr_next[i] = external_match_control_q[i];
      if (hit[i]) begin
        case (external_match_control_q[ptm_pkg::EM_ACT_POS + i*2 +: 2])
          ptm_pkg::EM_LOW: emr_next[i] = 1'b0;
          ptm_pkg::EM_HIGH: emr_next[i] = 1'b1;
          ptm_pkg::EM_TOGGLE: emr_next[i] = ~external_match_control_q[i];
          default: emr_next[i] = external_match_control_q[i];
        endcase
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      external_match_control_q <= 12'h0;
    end else if (wr && off == ptm_pkg::OFF_EXTM) begin
      external_match_control_q <= bus_wdata[11:0];
    end else begin
      external_match_control_q[3:0] <= emr_next;
    end
  end
  assign match_output = external_match_control_q[3:0] & 4'((1 << NMAT) - 1);
  genvar p;
  generate
    for (p = 0; p < NPIN; p++) begin : g_pin
      assign match_pins[p*4 +: 4] = match_output;
    end
  endgenerate

  // Read path, data one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_reg_q <= ptm_pkg::RESET_VAL;
      use_mem_q <= 1'b0;
    end else begin
      use_mem_q <= rd && off >= ptm_pkg::OFF_MATCH0 && off < ptm_pkg::OFF_CCTL
                || rd && off >= ptm_pkg::OFF_CAP0 && off < ptm_pkg::OFF_EXTM;
      rd_reg_q <= ptm_pkg::RESET_VAL;
      if (rd) begin
        case (off)
          ptm_pkg::OFF_FLAGS: rd_reg_q <= {24'h0, interrupt_flags_q};
          ptm_pkg::OFF_CTRL: rd_reg_q <= {30'h0, timer_control_q};
          ptm_pkg::OFF_COUNT: rd_reg_q <= timer_count_q;
          ptm_pkg::OFF_PLIM: rd_reg_q <= prescale_limit_q;
          ptm_pkg::OFF_PCNT: rd_reg_q <= prescale_counter_q;
          ptm_pkg::OFF_MCTL: rd_reg_q <= {20'h0, mctl_q};
          ptm_pkg::OFF_CCTL: rd_reg_q <= {20'h0, cctl_q};
          ptm_pkg::OFF_EXTM: rd_reg_q <= {20'h0, external_match_control_q};
          ptm_pkg::OFF_MODE: rd_reg_q <= {28'h0, mode_q};
          ptm_pkg::OFF_IMASK: rd_reg_q <= {24'h0, imask_q};
          default: rd_reg_q <= ptm_pkg::RESET_VAL;
        endcase
      end
    end
  end
  assign bus_rdata = use_mem_q ? mem_rdata : rd_reg_q;

  // Checks
  property p_step;
    @(posedge ref_clk) disable iff (!rstn)
    (count_step && !match_rst && !match_stop && !timer_control_q[1] && !(wr && off == ptm_pkg::OFF_COUNT))
      |=> timer_count_q == $past(timer_count_q) + 32'h1;
  endproperty
  a_step: assert property (p_step) else $error("count did not step");

  property p_pre;
    @(posedge ref_clk) disable iff (!rstn)
    (running && ext_edge && pre_wrap && !match_stop && !timer_control_q[1] && !wr)
      |=> prescale_counter_q == 32'h0;
  endproperty
  a_pre: assert property (p_pre) else $error("prescaler did not clear");

  property p_stop;
    @(posedge ref_clk) disable iff (!rstn)
    (match_stop && !wr) |=> !timer_control_q[0] ##1 !running;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt");

  property p_rst;
    @(posedge ref_clk) disable iff (!rstn)
    timer_control_q[1] |=> timer_count_q == 32'h0 && prescale_counter_q == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset hold failed");

  property p_irq;
    @(posedge ref_clk) disable iff (!rstn)
    (|(flag_set & imask_q)) && !(wr && off == ptm_pkg::OFF_IMASK) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missed an enabled flag");

  property p_clr;
    @(posedge ref_clk) disable iff (!rstn)
    (rd && off == ptm_pkg::OFF_FLAGS && flag_set == 8'h0) |=> interrupt_flags_q == 8'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared by read");

  property p_flag;
    @(posedge ref_clk) disable iff (!rstn)
    flag_set[0] |=> interrupt_flags_q[0];
  endproperty
  a_flag: assert property (p_flag) else $error("match flag lost");

  property p_cap;
    @(posedge ref_clk) disable iff (!rstn)
    cap_ev[0] |=> mem_all[159:128] == $past(timer_count_q);
  endproperty
  a_cap: assert property (p_cap) else $error("capture wrong");

  property p_tog;
    @(posedge ref_clk) disable iff (!rstn)
    (hit[3] && external_match_control_q[11:10] == ptm_pkg::EM_TOGGLE && !wr)
      |=> external_match_control_q[3] != $past(external_match_control_q[3]);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle missed");
endmodule : ptm_timer
`default_nettype wire

/* ptm_partner.sv */
// Far-side model: drives the capture lines and watches the match pin groups
`default_nettype none
module ptm_partner (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [3:0] cap_drive,
  input wire logic [7:0] match_pins,
  output logic [3:0] capture_input,
  output logic pins_agree
);
  // Levels move only on a clock edge because the timer samples them synchronously
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      capture_input <= 4'h0;
    end else begin
      capture_input <= cap_drive;
    end
  end
  // Every pin group must carry the same match state
  assign pins_agree = (match_pins[3:0] == match_pins[7:4]);
endmodule : ptm_partner
`default_nettype wire

/* ptm_timer_bench.sv */
// Self-checking bench for the prescaled timer with capture and match
`default_nettype none
module ptm_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BASE = 32'h4004_4000;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  ptm_pkg::ptm_req_t req = '0;
  logic [23:0] addr_hi = BASE[31:8];
  logic [31:0] bus_rdata;
  logic [3:0] cap_drive = 4'h0;
  logic [3:0] capture_input;
  logic [3:0] match_output;
  logic [7:0] match_pins;
  logic irq;
  logic pins_agree;
  int err_count = 0;
  int check_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  ptm_timer #(.NCAP(2), .NMAT(4), .NPIN(2), .BASE_ADDR(BASE)) i_ptm_timer (
    .ref_clk(ref_clk), .rstn(rstn), .bus_addr({addr_hi, req.addr}),
    .bus_wdata(req.wdata), .bus_wr(req.wr), .bus_rd(req.rd), .bus_rdata(bus_rdata),
    .capture_input(capture_input), .match_output(match_output),
    .match_pins(match_pins), .irq(irq));
  ptm_partner i_ptm_partner (
    .ref_clk(ref_clk), .rstn(rstn), .cap_drive(cap_drive), .match_pins(match_pins),
    .capture_input(capture_input), .pins_agree(pins_agree));
  task automatic print_verdict;
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask : bus_write
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    @(negedge ref_clk);
    d = bus_rdata;
  endtask : bus_read
  task automatic wait_irq(input int lim);
    int n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= lim) begin
      err_count++;
      print_verdict();
    end
  endtask : wait_irq
  task automatic restart;
    bus_write(ptm_pkg::OFF_CTRL, 32'h2);
    bus_write(ptm_pkg::OFF_CTRL, 32'h1);
  endtask : restart
  // Reset contents: only the interrupt mask comes up with all bits set
  function automatic logic [31:0] reset_of(input logic [7:0] a);
    return (a == ptm_pkg::OFF_IMASK) ? 32'h0000_00ff : ptm_pkg::RESET_VAL;
  endfunction : reset_of
  initial begin
    logic [31:0] c0;
    logic [31:0] c1;
    logic [31:0] v;
    logic [31:0] p;
    logic [31:0] n;
    void'($urandom(88));
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int a = 0; a < 128; a += 4) begin
      bus_read(8'(a), c0);
      check(c0, reset_of(8'(a)));
    end
    @(posedge ref_clk);
    addr_hi <= BASE[31:8] ^ 24'h00_0001;
    bus_read(ptm_pkg::OFF_IMASK, c0);
    check(c0, 32'h0);
    @(posedge ref_clk);
    addr_hi <= BASE[31:8];
    // Prescaled stepping: two reads (p+1)*4 cycles apart differ by four
    p = $urandom_range(6, 1);
    bus_write(ptm_pkg::OFF_PLIM, p);
    restart();
    bus_read(ptm_pkg::OFF_COUNT, c0);
    repeat (4 * (p + 1) - 2) @(posedge ref_clk);
    bus_read(ptm_pkg::OFF_COUNT, c1);
    check(c1 - c0, 32'h4);
    bus_write(ptm_pkg::OFF_CTRL, 32'h2);
    bus_read(ptm_pkg::OFF_COUNT, c0);
    check(c0, 32'h0);
    bus_read(ptm_pkg::OFF_PCNT, c0);
    check(c0, 32'h0);
    // Stop on match 0, with matches 0, 2 and 3 driving their outputs
    v = $urandom_range(40, 10);
    bus_write(ptm_pkg::OFF_MATCH0, v);
    bus_write(ptm_pkg::OFF_MATCH0 + 8'h08, v);
    bus_write(ptm_pkg::OFF_MATCH0 + 8'h0c, v);
    bus_write(ptm_pkg::OFF_MCTL, 32'h45);
    bus_write(ptm_pkg::OFF_EXTM, {20'h0, ptm_pkg::EM_TOGGLE, ptm_pkg::EM_LOW,
                                  ptm_pkg::EM_NONE, ptm_pkg::EM_HIGH, 4'h4});
    bus_write(ptm_pkg::OFF_PLIM, 32'h0);
    check({28'h0, match_output}, 32'h4);
    restart();
    wait_irq(400);
    repeat (3) @(posedge ref_clk);
    bus_read(ptm_pkg::OFF_COUNT, c0);
    check(c0, v);
    bus_read(ptm_pkg::OFF_CTRL, c0);
    check(c0, 32'h0);
    check({28'h0, match_output}, 32'h9);
    check({24'h0, match_pins}, 32'h99);
    check({31'h0, pins_agree}, 32'h1);
    bus_read(ptm_pkg::OFF_FLAGS, c0);
    check(c0, 32'h5);
    check({31'h0, irq}, 32'h0);
    // Capture while the count stands frozen at the match value
    bus_write(ptm_pkg::OFF_CCTL, 32'h15);
    cap_drive <= 4'h2;
    repeat (5) @(posedge ref_clk);
    cap_drive <= 4'h1;
    repeat (6) @(posedge ref_clk);
    bus_read(ptm_pkg::OFF_CAP0, c0);
    check(c0, v);
    bus_read(ptm_pkg::OFF_CAP0 + 8'h04, c0);
    check(c0, v);
    check({31'h0, irq}, 32'h1);
    bus_write(ptm_pkg::OFF_FLAGS, 32'h10);
    @(negedge ref_clk);
    check({31'h0, irq}, 32'h0);
    bus_read(ptm_pkg::OFF_FLAGS, c0);
    check(c0, 32'h0);
    // Reset on match 1 with its interrupt masked off
    v = $urandom_range(12, 4);
    bus_write(ptm_pkg::OFF_IMASK, 32'hfd);
    bus_write(ptm_pkg::OFF_MATCH0 + 8'h04, v);
    bus_write(ptm_pkg::OFF_MCTL, 32'h18);
    restart();
    for (int i = 0; i < 20; i++) begin
      repeat ($urandom_range(7, 0)) @(posedge ref_clk);
      bus_read(ptm_pkg::OFF_COUNT, c0);
      check({31'h0, c0 <= v}, 32'h1);
    end
    check({31'h0, irq}, 32'h0);
    bus_read(ptm_pkg::OFF_FLAGS, c0);
    check(c0, 32'h2);
    // Counter operation: rising then falling edges of input 0, then both edges of input 1
    bus_write(ptm_pkg::OFF_MCTL, 32'h0);
    for (int k = 0; k < 3; k++) begin
      bus_write(ptm_pkg::OFF_MODE, {28'h0, ((k == 2) ? 2'h1 : 2'h0),
                                    ((k == 0) ? ptm_pkg::MODE_RISE :
                                     (k == 1) ? ptm_pkg::MODE_FALL : ptm_pkg::MODE_BOTH)});
      restart();
      n = $urandom_range(9, 3);
      for (int i = 0; i < n; i++) begin
        cap_drive <= (k == 0) ? 4'h0 : (k == 1) ? 4'h1 : 4'h2;
        repeat (3) @(posedge ref_clk);
        cap_drive <= (k == 0) ? 4'h1 : 4'h0;
        repeat (3) @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
      bus_read(ptm_pkg::OFF_COUNT, c0);
      check(c0, (k == 2) ? 2 * n : n);
    end
    print_verdict();
  end
endmodule : ptm_timer_bench
`default_nettype wire
